// [ssd_regs.svh]
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// Timing
`define SSD_CLK_MHZ 100
`define SSD_WDOG_TIMEOUT_US 1000
`define SSD_RESTART_US 10
`define SSD_BOOT_WAIT_US 2000
`define SSD_RESTART_CYC (`SSD_RESTART_US * `SSD_CLK_MHZ)

// Diagnostic register indexes on the remote read port
`define SSD_REG_DIAG_ONE 2'h0
`define SSD_REG_DIAG_TWO 2'h1
`define SSD_REG_DIAG_THREE 2'h2
`define SSD_REG_DIAG_FOUR 2'h3
`define SSD_DIAG_RESET 16'h0000

// Event codes
`define SSD_EVT_FAULT_ON 8'h38
`define SSD_EVT_FAULT_OFF 8'h39
`define SSD_EVT_NONE 8'h00

// First register fields
`define SSD_D1_RELAY_A 0
`define SSD_D1_RELAY_B 1
`define SSD_D1_AUX_LO 4
`define SSD_D1_AUX_HI 8

// Third register fields
`define SSD_D3_ANALOG_OUT 0
`define SSD_D3_STACK 1
`define SSD_D3_MEMCHECK 2
`define SSD_D3_BG_TIMEOUT 3
`define SSD_D3_INPUT 4
`define SSD_D3_ARC 6
`define SSD_D3_SEC_PULSE 7
`define SSD_D3_RANGE 8
`define SSD_D3_OVERLOAD 9
`define SSD_D3_POS_RAIL 10
`define SSD_D3_NEG_RAIL 11
`define SSD_D3_OVERTEMP 12
`define SSD_D3_CONV_ONE 13
`define SSD_D3_CONV_TWO 14
`define SSD_D3_NONVOL 15

// Fourth register fields
`define SSD_D4_COMM_BUF 1

// Fault records
`define SSD_PCT_FULL 7'h64
`define SSD_PCT_MAX_RUN 7'h63
`define SSD_REC_PTR_ONE 3'h1
`define SSD_REC_COUNT_FULL 4'h8

`endif

// [ssd_pkg.sv]
package ssd_pkg;

  typedef enum logic [1:0] {
    WD_BOOT_WAIT,
    WD_RUN,
    WD_RESTART,
    WD_PERM
  } wd_state_t;

  typedef struct packed {
    logic out_relay_fault_a;
    logic out_relay_fault_b;
    logic [4:0] aux_fault;
    logic analog_out_fault;
    logic stack_fault;
    logic memory_check_fault;
    logic background_timeout;
    logic input_fault;
    logic arc_card_fault;
    logic seconds_pulse_fault;
    logic setting_range_fault;
    logic processor_overload;
    logic positive_rail_fault;
    logic negative_rail_fault;
    logic overtemperature;
    logic converter_check_one;
    logic converter_check_two;
    logic nonvolatile_fault;
    logic comm_buffer_fault;
  } fault_in_t;

  typedef struct packed {
    logic [15:0] one;
    logic [15:0] three;
    logic [15:0] four;
  } diag_regs_t;

  typedef struct packed {
    logic [31:0] date;
    logic [31:0] time_of_day;
    logic [15:0] fault_value;
    logic [15:0] elapsed;
    logic [15:0] op_time;
    logic tripped;
    logic active_group;
  } rec_in_t;

  typedef struct packed {
    logic [31:0] date;
    logic [31:0] time_of_day;
    logic [15:0] fault_value;
    logic [6:0] elapsed_delay_pct;
    logic active_group;
  } rec_t;

endpackage

// [fault_record_ram.sv]
`timescale 1ns/1ns
module fault_record_ram
  import ssd_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_wr_en,
  input wire logic [5:0] i_wr_addr,
  input wire rec_t i_wr_data,
  input wire logic i_rd_en,
  input wire logic [5:0] i_rd_addr,
  output rec_t o_rd_data
);

  rec_t mem [0:63];

  always_ff @(posedge i_core_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end

endmodule

// [self_supervision_diagnostics.sv]
// Function
// - Watchdog pulses the controller restart when heartbeats stop.
// - Restart without a following heartbeat latches the permanent fault.
// - Permanent fault blocks every output relay except the supervision relay.
// - Boot test result and continuous runtime fault inputs are both checked.
// - Permanent fault drops the supervision relay, lights the LED, shows message.
// - A new temporary fault sets the matrix flag and emits fault-on event.
// - Temporary fault clearing emits the fault-off event.
// - Matrix flag holds until the panel reset command clears it.
// - Three 16-bit diagnostic registers (first, third, fourth) are readable over the remote port; the second index reads zero.
// - First register: bit 0, bit 1 relay faults, bits 4-8 aux faults.
// - Third register bits 0-3: analog out, stack, memory check, background timeout.
// - Third register bits 4, 6, 7: input, arc card, seconds pulse; bit 5 unused.
// - Third register bit 8 setting range, bit 9 processor overload.
// - Third register bits 10, 11 supply rails, bit 12 overtemperature.
// - Third register bits 13, 14 converter checks, bit 15 nonvolatile fault.
// - Fourth register bit 1 flags a communication buffer fault.
// - Events and panel menu carry the active diagnostic bits.
// - Each stage keeps eight recent records: stamp, fault value, elapsed delay.
// - Elapsed delay stored as percent of operating time, full value on trip.
// - Each record stores the active setting group.
`timescale 1ns/1ns
`include "ssd_regs.svh"
module self_supervision_diagnostics
  import ssd_pkg::*;
#(
  parameter logic [31:0] WDOG_TIMEOUT_CYC = `SSD_WDOG_TIMEOUT_US * `SSD_CLK_MHZ,
  parameter logic [31:0] BOOT_WAIT_CYC = `SSD_BOOT_WAIT_US * `SSD_CLK_MHZ
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_heartbeat,
  input wire logic i_boot_done,
  input wire logic i_boot_pass,
  input wire fault_in_t i_faults,
  input wire logic i_panel_reset,
  input wire logic [7:0] i_relay_req,
  input wire logic i_reg_rd,
  input wire logic [1:0] i_reg_addr,
  input wire logic i_rec_wr,
  input wire logic [2:0] i_rec_stage,
  input wire rec_in_t i_rec,
  input wire logic i_rec_rd,
  input wire logic [2:0] i_rec_rd_stage,
  input wire logic [2:0] i_rec_rd_idx,
  output logic o_mcu_reset_n,
  output logic o_supervision_relay,
  output logic o_status_led,
  output logic o_panel_fault_msg,
  output logic [7:0] o_relay_ctrl,
  output logic o_matrix_flag,
  output logic o_event_valid,
  output logic [7:0] o_event_code,
  output diag_regs_t o_event_diag,
  output diag_regs_t o_diag_menu,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output rec_t o_rec_rdata,
  output logic o_rec_rvalid,
  output logic o_rec_rhit
);

  localparam logic [31:0] RESTART_CYC = 32'(`SSD_RESTART_CYC);

  // Heartbeat pin synchroniser and edge detect
  logic hb_sync1_r, hb_sync2_r, hb_prev_r;
  logic hb_edge;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hb_sync1_r <= 1'b0;
      hb_sync2_r <= 1'b0;
      hb_prev_r <= 1'b0;
    end else begin
      hb_sync1_r <= i_heartbeat;
      hb_sync2_r <= hb_sync1_r;
      hb_prev_r <= hb_sync2_r;
    end
  end

  assign hb_edge = hb_sync2_r & ~hb_prev_r;

  // Watchdog
  wd_state_t wd_state_r, wd_state_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic boot_fail;
  logic perm;

  assign boot_fail = i_boot_done & ~i_boot_pass;

  always_comb begin
    wd_state_nxt = wd_state_r;
    wd_cnt_nxt = wd_cnt_r + 32'h1;
    case (wd_state_r)
      WD_BOOT_WAIT: begin
        if (boot_fail) begin
          wd_state_nxt = WD_PERM;
        end else if (hb_edge) begin
          wd_state_nxt = WD_RUN;
          wd_cnt_nxt = '0;
        end else if (wd_cnt_r >= BOOT_WAIT_CYC - 32'h1) begin
          wd_state_nxt = WD_PERM;
        end
      end
      WD_RUN: begin
        if (boot_fail) begin
          wd_state_nxt = WD_PERM;
        end else if (hb_edge) begin
          wd_cnt_nxt = '0;
        end else if (wd_cnt_r >= WDOG_TIMEOUT_CYC - 32'h1) begin
          wd_state_nxt = WD_RESTART;
          wd_cnt_nxt = '0;
        end
      end
      WD_RESTART: begin
        if (wd_cnt_r >= RESTART_CYC - 32'h1) begin
          wd_state_nxt = WD_BOOT_WAIT;
          wd_cnt_nxt = '0;
        end
      end
      WD_PERM: begin
        wd_cnt_nxt = wd_cnt_r;
      end
      default: begin
        wd_state_nxt = WD_PERM;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wd_state_r <= WD_BOOT_WAIT;
      wd_cnt_r <= '0;
    end else begin
      wd_state_r <= wd_state_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  assign perm = (wd_state_r == WD_PERM);
  assign o_mcu_reset_n = (wd_state_r != WD_RESTART);
  assign o_supervision_relay = ~perm;
  assign o_status_led = perm;
  assign o_panel_fault_msg = perm;
  assign o_relay_ctrl = perm ? 8'h00 : i_relay_req;

  // Diagnostic registers and temporary fault events
  diag_regs_t diag_r, diag_nxt;
  logic temp_r, temp_nxt;
  logic matrix_r, matrix_nxt;
  logic evt_valid_r, evt_valid_nxt;
  logic [7:0] evt_code_r, evt_code_nxt;
  diag_regs_t evt_diag_r, evt_diag_nxt;
  logic any_fault, fault_on, fault_off;

  always_comb begin
    diag_nxt = '0;
    diag_nxt.one[`SSD_D1_RELAY_A] = i_faults.out_relay_fault_a;
    diag_nxt.one[`SSD_D1_RELAY_B] = i_faults.out_relay_fault_b;
    diag_nxt.one[`SSD_D1_AUX_HI:`SSD_D1_AUX_LO] = i_faults.aux_fault;
    diag_nxt.three[`SSD_D3_ANALOG_OUT] = i_faults.analog_out_fault;
    diag_nxt.three[`SSD_D3_STACK] = i_faults.stack_fault;
    diag_nxt.three[`SSD_D3_MEMCHECK] = i_faults.memory_check_fault;
    diag_nxt.three[`SSD_D3_BG_TIMEOUT] = i_faults.background_timeout;
    diag_nxt.three[`SSD_D3_INPUT] = i_faults.input_fault;
    diag_nxt.three[`SSD_D3_ARC] = i_faults.arc_card_fault;
    diag_nxt.three[`SSD_D3_SEC_PULSE] = i_faults.seconds_pulse_fault;
    diag_nxt.three[`SSD_D3_RANGE] = i_faults.setting_range_fault;
    diag_nxt.three[`SSD_D3_OVERLOAD] = i_faults.processor_overload;
    diag_nxt.three[`SSD_D3_POS_RAIL] = i_faults.positive_rail_fault;
    diag_nxt.three[`SSD_D3_NEG_RAIL] = i_faults.negative_rail_fault;
    diag_nxt.three[`SSD_D3_OVERTEMP] = i_faults.overtemperature;
    diag_nxt.three[`SSD_D3_CONV_ONE] = i_faults.converter_check_one;
    diag_nxt.three[`SSD_D3_CONV_TWO] = i_faults.converter_check_two;
    diag_nxt.three[`SSD_D3_NONVOL] = i_faults.nonvolatile_fault;
    diag_nxt.four[`SSD_D4_COMM_BUF] = i_faults.comm_buffer_fault;
  end

  assign any_fault = |diag_r;
  assign fault_on = any_fault & ~temp_r;
  assign fault_off = ~any_fault & temp_r;

  always_comb begin
    temp_nxt = any_fault;
    // Set wins over a panel reset in the same cycle
    matrix_nxt = fault_on | (matrix_r & ~i_panel_reset);
    evt_valid_nxt = fault_on | fault_off;
    evt_code_nxt = fault_on ? `SSD_EVT_FAULT_ON :
                   fault_off ? `SSD_EVT_FAULT_OFF : `SSD_EVT_NONE;
    evt_diag_nxt = (fault_on | fault_off) ? diag_r : evt_diag_r;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      diag_r <= {`SSD_DIAG_RESET, `SSD_DIAG_RESET, `SSD_DIAG_RESET};
      temp_r <= 1'b0;
      matrix_r <= 1'b0;
      evt_valid_r <= 1'b0;
      evt_code_r <= `SSD_EVT_NONE;
      evt_diag_r <= '0;
    end else begin
      diag_r <= diag_nxt;
      temp_r <= temp_nxt;
      matrix_r <= matrix_nxt;
      evt_valid_r <= evt_valid_nxt;
      evt_code_r <= evt_code_nxt;
      evt_diag_r <= evt_diag_nxt;
    end
  end

  assign o_matrix_flag = matrix_r;
  assign o_event_valid = evt_valid_r;
  assign o_event_code = evt_code_r;
  assign o_event_diag = evt_diag_r;
  assign o_diag_menu = diag_r;

  // Remote register read port
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  always_comb begin
    rvalid_nxt = i_reg_rd;
    rdata_nxt = rdata_r;
    if (i_reg_rd) begin
      if (i_reg_addr == `SSD_REG_DIAG_ONE) begin
        rdata_nxt = diag_r.one;
      end else if (i_reg_addr == `SSD_REG_DIAG_THREE) begin
        rdata_nxt = diag_r.three;
      end else if (i_reg_addr == `SSD_REG_DIAG_FOUR) begin
        rdata_nxt = diag_r.four;
      end else begin
        rdata_nxt = `SSD_DIAG_RESET;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= `SSD_DIAG_RESET;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_reg_rvalid = rvalid_r;

  // Fault record rings, one per stage
  logic [2:0] wr_ptr_r [8];
  logic [3:0] count_r [8];
  logic [22:0] pct_prod;
  logic [22:0] pct_quot;
  rec_t rec_wdata;
  logic [2:0] rd_slot;
  logic rec_rvalid_r, rec_rvalid_nxt;
  logic rec_rhit_r, rec_rhit_nxt;

  genvar s;
  generate
    for (s = 0; s < 8; s++) begin : g_stage
      logic [2:0] ptr_nxt;
      logic [3:0] cnt_nxt;
      always_comb begin
        ptr_nxt = wr_ptr_r[s];
        cnt_nxt = count_r[s];
        if (i_rec_wr && (i_rec_stage == 3'(s))) begin
          ptr_nxt = wr_ptr_r[s] + `SSD_REC_PTR_ONE;
          if (count_r[s] != `SSD_REC_COUNT_FULL) begin
            cnt_nxt = count_r[s] + 4'h1;
          end
        end
      end
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          wr_ptr_r[s] <= 3'h0;
          count_r[s] <= 4'h0;
        end else begin
          wr_ptr_r[s] <= ptr_nxt;
          count_r[s] <= cnt_nxt;
        end
      end
    end
  endgenerate

  always_comb begin
    pct_prod = {7'h00, i_rec.elapsed} * {16'h0000, `SSD_PCT_FULL};
    pct_quot = (i_rec.op_time == 16'h0000) ? 23'h0 : pct_prod / {7'h00, i_rec.op_time};
    rec_wdata.date = i_rec.date;
    rec_wdata.time_of_day = i_rec.time_of_day;
    rec_wdata.fault_value = i_rec.fault_value;
    rec_wdata.active_group = i_rec.active_group;
    if (i_rec.tripped) begin
      rec_wdata.elapsed_delay_pct = `SSD_PCT_FULL;
    end else if (pct_quot > {16'h0000, `SSD_PCT_MAX_RUN}) begin
      // A stage that has not tripped never shows the full value
      rec_wdata.elapsed_delay_pct = `SSD_PCT_MAX_RUN;
    end else begin
      rec_wdata.elapsed_delay_pct = pct_quot[6:0];
    end
  end

  // Index 0 is the newest record of the stage
  assign rd_slot = wr_ptr_r[i_rec_rd_stage] - `SSD_REC_PTR_ONE - i_rec_rd_idx;

  always_comb begin
    rec_rvalid_nxt = i_rec_rd;
    rec_rhit_nxt = rec_rhit_r;
    if (i_rec_rd) begin
      rec_rhit_nxt = ({1'b0, i_rec_rd_idx} < count_r[i_rec_rd_stage]);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rec_rvalid_r <= 1'b0;
      rec_rhit_r <= 1'b0;
    end else begin
      rec_rvalid_r <= rec_rvalid_nxt;
      rec_rhit_r <= rec_rhit_nxt;
    end
  end

  fault_record_ram i_fault_record_ram (
    .i_core_clk(i_core_clk),
    .i_wr_en(i_rec_wr),
    .i_wr_addr({i_rec_stage, wr_ptr_r[i_rec_stage]}),
    .i_wr_data(rec_wdata),
    .i_rd_en(i_rec_rd),
    .i_rd_addr({i_rec_rd_stage, rd_slot}),
    .o_rd_data(o_rec_rdata)
  );

  assign o_rec_rvalid = rec_rvalid_r;
  assign o_rec_rhit = rec_rhit_r;

  // Checks
  restart_on_timeout_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (wd_state_r == WD_RUN && wd_cnt_r == WDOG_TIMEOUT_CYC - 32'h1 && !hb_edge && !boot_fail)
    |=> !o_mcu_reset_n ##1 !o_mcu_reset_n) else $error("restart not issued on timeout");
  perm_after_fail_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (wd_state_r == WD_BOOT_WAIT && wd_cnt_r == BOOT_WAIT_CYC - 32'h1 && !hb_edge)
    |=> perm) else $error("failed restart did not latch permanent fault");
  relays_blocked_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    perm |-> (o_relay_ctrl == 8'h00 && !o_supervision_relay)) else $error("relay not blocked");
  boot_fail_perm_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (boot_fail && wd_state_r != WD_RESTART) |=> perm [*3]) else $error("boot fail ignored");
  perm_indicate_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $rose(perm) |-> (o_status_led && o_panel_fault_msg && $fell(o_supervision_relay)))
    else $error("permanent fault indication missing");
  fault_on_evt_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (any_fault && !temp_r) |=> (o_event_valid && o_event_code == `SSD_EVT_FAULT_ON
    && o_matrix_flag)) else $error("fault-on event missing");
  fault_off_evt_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    $fell(any_fault) |=> (o_event_valid && o_event_code == `SSD_EVT_FAULT_OFF))
    else $error("fault-off event missing");
  matrix_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (o_matrix_flag && !i_panel_reset) |=> o_matrix_flag) else $error("matrix flag lost");
  matrix_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_panel_reset && !fault_on) |=> !o_matrix_flag) else $error("matrix flag not cleared");
  reg_read_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_reg_rd && i_reg_addr == `SSD_REG_DIAG_THREE) |=>
    (o_reg_rvalid && o_reg_rdata == $past(diag_r.three))) else $error("bad register read");
  unused_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    (diag_r.three[5] == 1'b0 && diag_r.one[3:2] == 2'b00 && diag_r.one[15:9] == 7'h00))
    else $error("unassigned bit set");
  pct_range_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
    i_rec_wr |-> ((rec_wdata.elapsed_delay_pct == `SSD_PCT_FULL) == i_rec.tripped))
    else $error("elapsed percent wrong");

  perm_seen_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn) $rose(perm));
  restart_ok_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    (wd_state_r == WD_BOOT_WAIT && hb_edge && !boot_fail));
  event_pair_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    (o_event_code == `SSD_EVT_FAULT_ON && o_event_valid) ##[1:50]
    (o_event_code == `SSD_EVT_FAULT_OFF && o_event_valid));
  ring_wrap_c: cover property (@(posedge i_core_clk) disable iff (!i_resetn)
    (i_rec_wr && count_r[i_rec_stage] == `SSD_REC_COUNT_FULL));

endmodule

// [controller_model.sv]
`timescale 1ns/1ns
module controller_model (
  input wire logic i_core_clk,
  input wire logic i_mcu_reset_n,
  input wire logic i_alive,
  output logic o_heartbeat
);
  logic [3:0] div_r;
  initial begin
    div_r = 4'h0;
    o_heartbeat = 1'b0;
  end
  // A controller held in restart or hung keeps its heartbeat pin quiet
  always @(posedge i_core_clk) begin
    if (!i_mcu_reset_n || !i_alive) begin
      div_r <= 4'h0;
      o_heartbeat <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      if (div_r == 4'h7) begin
        o_heartbeat <= ~o_heartbeat;
      end
    end
  end
endmodule

// [testbench.sv]
`timescale 1ns/1ns
module testbench;
  import ssd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic alive = 1'b1;
  logic boot_done = 1'b1;
  logic boot_pass = 1'b1;
  logic panel_reset = 1'b0;
  logic reg_rd = 1'b0;
  logic rec_wr = 1'b0;
  logic rec_rd = 1'b0;
  logic [7:0] relay_req = 8'h00;
  logic [1:0] reg_addr = 2'h0;
  logic [2:0] rec_stage = 3'h0;
  logic [2:0] rd_stage = 3'h0;
  logic [2:0] rd_idx = 3'h0;
  fault_in_t faults = '0;
  rec_in_t rec_in = '0;
  logic hb, mcu_rn, sup, led, msg, matrix, ev_valid, reg_rvalid, rec_rvalid, rec_rhit;
  logic [7:0] relay_ctrl;
  logic [7:0] ev_code;
  logic [15:0] reg_rdata;
  diag_regs_t ev_diag;
  diag_regs_t menu;
  rec_t rec_rdata;
  int fails = 0;
  int n_compared = 0;

  always #5 clk = ~clk;

  self_supervision_diagnostics #(
    .WDOG_TIMEOUT_CYC(32'd50),
    .BOOT_WAIT_CYC(32'd80)
  ) i_self_supervision_diagnostics (
    .i_core_clk(clk), .i_resetn(resetn), .i_heartbeat(hb), .i_boot_done(boot_done),
    .i_boot_pass(boot_pass), .i_faults(faults), .i_panel_reset(panel_reset),
    .i_relay_req(relay_req), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_rec_wr(rec_wr),
    .i_rec_stage(rec_stage), .i_rec(rec_in), .i_rec_rd(rec_rd), .i_rec_rd_stage(rd_stage),
    .i_rec_rd_idx(rd_idx), .o_mcu_reset_n(mcu_rn), .o_supervision_relay(sup),
    .o_status_led(led), .o_panel_fault_msg(msg), .o_relay_ctrl(relay_ctrl),
    .o_matrix_flag(matrix), .o_event_valid(ev_valid), .o_event_code(ev_code),
    .o_event_diag(ev_diag), .o_diag_menu(menu), .o_reg_rdata(reg_rdata),
    .o_reg_rvalid(reg_rvalid), .o_rec_rdata(rec_rdata), .o_rec_rvalid(rec_rvalid),
    .o_rec_rhit(rec_rhit)
  );

  controller_model i_controller_model (
    .i_core_clk(clk), .i_mcu_reset_n(mcu_rn), .i_alive(alive), .o_heartbeat(hb)
  );

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [87:0] seen, input logic [87:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic timeout();
    fails++;
    final_report();
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    repeat (10) tick();
    check({mcu_rn, sup, led, msg, matrix, ev_valid, reg_rvalid}, 7'h60);
    resetn = 1'b1;
    tick();
    $display("reset done");
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [15:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    check(reg_rvalid, 1'b1);
    d = reg_rdata;
    tick();
  endtask

  task automatic test_diag();
    logic [15:0] d;
    logic [15:0] e [4];
    for (int k = 0; k <= 23; k++) begin
      faults = (k == 23) ? '0 : fault_in_t'(23'h1 << k);
      e = '{default: 16'h0000};
      if (k == 0) e[3][1] = 1'b1;
      else if (k <= 10) e[2][16 - k] = 1'b1;
      else if (k <= 15) e[2][15 - k] = 1'b1;
      else if (k <= 20) e[0][k - 12] = 1'b1;
      else if (k < 23) e[0][22 - k] = 1'b1;
      tick();
      tick();
      for (int r = 0; r < 4; r++) begin
        reg_read(2'(r), d);
        check(d, e[r]);
      end
      check(menu, {e[0], e[2], e[3]});
    end
    $display("test_diag done");
  endtask

  task automatic wait_event(output logic [7:0] c);
    int n;
    for (n = 0; n < 10 && ev_valid !== 1'b1; n++) tick();
    if (n == 10) timeout();
    c = ev_code;
  endtask

  task automatic pulse_panel();
    panel_reset = 1'b1;
    tick();
    panel_reset = 1'b0;
    tick();
  endtask

  task automatic test_events();
    logic [7:0] c;
    pulse_panel();
    check(matrix, 1'b0);
    faults.stack_fault = 1'b1;
    wait_event(c);
    check(c, 8'h38);
    check(matrix, 1'b1);
    check(ev_diag.three, 16'h0002);
    tick();
    check(ev_valid, 1'b0);
    faults = '0;
    wait_event(c);
    check(c, 8'h39);
    check(matrix, 1'b1);
    pulse_panel();
    check(matrix, 1'b0);
    faults.arc_card_fault = 1'b1;
    tick();
    panel_reset = 1'b1;
    tick();
    panel_reset = 1'b0;
    check({ev_valid, matrix}, 2'h3);
    tick();
    faults = '0;
    wait_event(c);
    check(c, 8'h39);
    pulse_panel();
    $display("test_events done");
  endtask

  task automatic rec_read(input logic [2:0] s, input logic [2:0] i, input logic h, input rec_t e);
    rec_rd = 1'b1;
    rd_stage = s;
    rd_idx = i;
    tick();
    rec_rd = 1'b0;
    check(rec_rvalid, 1'b1);
    check(rec_rhit, h);
    if (h) check(rec_rdata, e);
    tick();
  endtask

  task automatic test_records();
    rec_t e [10];
    int p;
    for (int k = 1; k <= 9; k++) begin
      p = k * 2500 / 200;
      rec_in.date = 32'(k);
      rec_in.time_of_day = 32'(k * 1000);
      rec_in.fault_value = 16'(k + 256);
      rec_in.elapsed = 16'(k * 25);
      rec_in.op_time = 16'h00c8;
      rec_in.tripped = (k == 9);
      rec_in.active_group = k[0];
      e[k] = {rec_in.date, rec_in.time_of_day, rec_in.fault_value,
              7'(k == 9 ? 100 : (p > 99 ? 99 : p)), k[0]};
      rec_wr = 1'b1;
      rec_stage = 3'h2;
      tick();
    end
    rec_wr = 1'b0;
    for (int i = 0; i < 8; i++) rec_read(3'h2, 3'(i), 1'b1, e[9 - i]);
    rec_read(3'h3, 3'h0, 1'b0, e[1]);
    $display("test_records done");
  endtask

  task automatic restart_cycle(input logic back);
    int n;
    alive = 1'b0;
    for (n = 0; n < 200 && mcu_rn !== 1'b0; n++) tick();
    if (n == 200) timeout();
    alive = back;
    for (n = 0; n < 2000 && mcu_rn !== 1'b1; n++) tick();
    if (n == 2000) timeout();
    check(n, 1000);
  endtask

  task automatic test_watchdog();
    int n;
    relay_req = 8'ha5;
    boot_done = 1'b0;
    boot_pass = 1'b0;
    tick();
    tick();
    check({sup, relay_ctrl}, 9'h1a5);
    boot_done = 1'b1;
    boot_pass = 1'b1;
    restart_cycle(1'b1);
    repeat (300) tick();
    check({sup, led, msg}, 3'h4);
    restart_cycle(1'b0);
    for (n = 0; n < 300 && sup !== 1'b0; n++) tick();
    if (n == 300) timeout();
    check({sup, led, msg, relay_ctrl}, 11'h300);
    repeat (1200) tick();
    check(mcu_rn, 1'b1);
    alive = 1'b1;
    do_reset();
    boot_pass = 1'b0;
    tick();
    tick();
    check({sup, led, relay_ctrl}, 10'h100);
    boot_pass = 1'b1;
    $display("test_watchdog done");
  endtask

  initial begin
    do_reset();
    test_diag();
    test_events();
    test_records();
    test_watchdog();
    final_report();
  end
endmodule
